// ===== common/dlsb_defs.vh
// constants for the drive log sector builder (directory and extended error log sectors)
// Summary of operation
// - directory version word at 00h reads 0001h
// - version 0000h only when directory unsupported
// - sector count per log address at 2N
// - logs 80h-9Fh report sixteen sectors each
// - byte 020h follows queuing flag, 021h zero
// - byte 022h follows event counter flag, 023h zero
// - byte 024h follows non-data flag, 025h zero
// - byte 02Ah follows rebuild flag, 02Bh zero
// - faulty commands never create error entries
// - error log version 01h, reserved byte
// - index names newest entry, 0 to 4
// - four 124-byte entries at fixed offsets
// - entries overwrite slots circularly
// - unfilled slots read as zero bytes
// - device error count saturates, never wraps
// - five command snapshots then error snapshot
// - command snapshot byte layout with timestamp
// - pair low latest write, high previous
// - error snapshot byte layout with hours
// - pair low hob clear, high hob set
// - state low nibble carries power state
`ifndef DLSB_DEFS_VH
`define DLSB_DEFS_VH

// apb map, byte addresses
`define DLSB_DIR_BASE 12'h000
`define DLSB_ELOG_BASE 12'h200
`define DLSB_CFG_ADDR 12'h400
`define DLSB_STAT_ADDR 12'h404

// config register fields and reset value
`define DLSB_CFG_DIRSUP 0
`define DLSB_CFG_NCQ 1
`define DLSB_CFG_PHYEV 2
`define DLSB_CFG_NCQND 3
`define DLSB_CFG_REBUILD 4
`define DLSB_CFG_RESET 5'h01

// directory sector
`define DLSB_DIR_VERSION 8'h01
`define DLSB_DIR_VENDOR_LO 8'h80
`define DLSB_DIR_VENDOR_HI 8'h9f
`define DLSB_VENDOR_SECTORS 8'h10
`define DLSB_DIR_ELOG_BYTE 9'h006
`define DLSB_DIR_NCQ_BYTE 9'h020
`define DLSB_DIR_PHYEV_BYTE 9'h022
`define DLSB_DIR_NCQND_BYTE 9'h024
`define DLSB_DIR_REBUILD_BYTE 9'h02a

// error log sector
`define DLSB_ELOG_VERSION 8'h01
`define DLSB_SLOT0_OFS 9'h004
`define DLSB_SLOT1_OFS 9'h080
`define DLSB_SLOT2_OFS 9'h0fc
`define DLSB_SLOT3_OFS 9'h178
`define DLSB_COUNT_OFS 9'h1f4
`define DLSB_CSUM_OFS 9'h1ff
`define DLSB_ENTRY_BYTES 124
`define DLSB_CMD_BYTES 18
`define DLSB_NUM_SLOTS 4
`define DLSB_NUM_CMDS 5

// timing
`define DLSB_CLK_PERIOD_NS 40
`define DLSB_MS_NS 1000000
`define DLSB_HOUR_MS 3600000

`endif

// ===== design/dlsb_log_builder.v
// log sector builder: apb slave serving the log directory and extended error log sectors
//
// Chosen here: the placing of the registers and the APB register port.
`default_nettype none
`include "dlsb_defs.vh"

module dlsb_log_builder #(
	parameter integer MS_CYCLES = `DLSB_MS_NS / `DLSB_CLK_PERIOD_NS,
	parameter integer HOUR_MS = `DLSB_HOUR_MS,
	parameter [7:0] ELOG_SECTORS = 8'h01
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// task file writes from the host interface logic
	input wire tfWrStb,
	input wire [2:0] tfWrAddr,
	input wire [7:0] tfWrData,
	// command issue
	input wire cmdStb,
	input wire [7:0] cmdCode,
	// error report
	input wire errStb,
	input wire errFaulty,
	input wire [7:0] errReg,
	input wire [7:0] errStatus,
	input wire [7:0] errHead,
	input wire [63:0] errTf,
	input wire [3:0] powerState
);

	localparam integer ENTRY_W = 8 * `DLSB_ENTRY_BYTES;
	localparam integer CMD_W = 8 * `DLSB_CMD_BYTES;

	// task file shadow: five pairs, head and control
	reg [7:0] tfLo_q [0:4];
	reg [7:0] tfHi_q [0:4];
	reg [7:0] head_q;
	reg [7:0] ctrl_q;
	// command history, index 4 newest
	reg [CMD_W-1:0] hist_q [0:4];
	// error slots
	reg [ENTRY_W-1:0] slot_q [0:3];
	reg [7:0] slotSum_q [0:3];
	reg [3:0] filled_q;
	reg [2:0] index_q;
	reg [15:0] errCount_q;
	// time keeping
	reg [31:0] cycCnt_q;
	reg [31:0] msStamp_q;
	reg [31:0] hourMs_q;
	reg [15:0] hours_q;
	// configuration
	reg [4:0] cfg_q;

	// directory byte at a sector offset
	function [7:0] dirByte;
		input [8:0] a;
		input [4:0] cfg;
		begin
			dirByte = 8'h00;
			if (cfg[`DLSB_CFG_DIRSUP]) begin
				if (a == 9'h000)
					dirByte = `DLSB_DIR_VERSION;
				else if (a[0] == 1'b0 && a[8:1] >= `DLSB_DIR_VENDOR_LO && a[8:1] <= `DLSB_DIR_VENDOR_HI)
					dirByte = `DLSB_VENDOR_SECTORS;
				else if (a == `DLSB_DIR_ELOG_BYTE)
					dirByte = ELOG_SECTORS;
				else if (a == `DLSB_DIR_NCQ_BYTE)
					dirByte = {7'h00, cfg[`DLSB_CFG_NCQ]};
				else if (a == `DLSB_DIR_PHYEV_BYTE)
					dirByte = {7'h00, cfg[`DLSB_CFG_PHYEV]};
				else if (a == `DLSB_DIR_NCQND_BYTE)
					dirByte = {7'h00, cfg[`DLSB_CFG_NCQND]};
				else if (a == `DLSB_DIR_REBUILD_BYTE)
					dirByte = {7'h00, cfg[`DLSB_CFG_REBUILD]};
			end
			// unsupported directory reads as all zero, version word 0000h
		end
	endfunction

	// byte sum of an entry
	function [7:0] entrySum;
		input [ENTRY_W-1:0] e;
		integer k;
		begin
			entrySum = 8'h00;
			for (k = 0; k < `DLSB_ENTRY_BYTES; k = k + 1) begin
				entrySum = entrySum + e[8*k +: 8];
			end
		end
	endfunction

	// command snapshot from current shadow state and time stamp
	wire [CMD_W-1:0] cmdSnap;
	assign cmdSnap = {msStamp_q, 8'h00, cmdCode, head_q,
		tfHi_q[4], tfLo_q[4], tfHi_q[3], tfLo_q[3], tfHi_q[2], tfLo_q[2],
		tfHi_q[1], tfLo_q[1], tfHi_q[0], tfLo_q[0], ctrl_q};

	// error snapshot; errTf pairs arrive as hob-clear low byte, hob-set high byte
	wire [271:0] errSnap;
	assign errSnap = {hours_q, {4'h0, powerState}, 152'h0, errStatus, errHead, errTf, errReg, 8'h00};

	// full entry: oldest command first, failing error snapshot last
	wire [ENTRY_W-1:0] newEntry;
	assign newEntry = {errSnap, hist_q[4], hist_q[3], hist_q[2], hist_q[1], hist_q[0]};
	wire [7:0] newSum;
	assign newSum = entrySum(newEntry);

	// next slot number, 1..4, wrapping after the fourth
	wire [2:0] nextIndex;
	assign nextIndex = (index_q == 3'd0 || index_q == 3'd4) ? 3'd1 : index_q + 3'd1;
	wire logIt;
	assign logIt = errStb & ~errFaulty;

	// free running millisecond and hour time base
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cycCnt_q <= 32'h0;
			msStamp_q <= 32'h0;
			hourMs_q <= 32'h0;
			hours_q <= 16'h0;
		end else if (cycCnt_q == MS_CYCLES - 1) begin
			cycCnt_q <= 32'h0;
			msStamp_q <= msStamp_q + 32'h1;
			if (hourMs_q == HOUR_MS - 1) begin
				hourMs_q <= 32'h0;
				hours_q <= hours_q + 16'h1;
			end else begin
				hourMs_q <= hourMs_q + 32'h1;
			end
		end else begin
			cycCnt_q <= cycCnt_q + 32'h1;
		end
	end

	// task file shadow: a pair write pushes the previous value into the high byte
	integer p;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (p = 0; p < 5; p = p + 1) begin
				tfLo_q[p] <= 8'h00;
				tfHi_q[p] <= 8'h00;
			end
			head_q <= 8'h00;
			ctrl_q <= 8'h00;
		end else if (tfWrStb) begin
			if (tfWrAddr < 3'd5) begin
				tfHi_q[tfWrAddr] <= tfLo_q[tfWrAddr];
				tfLo_q[tfWrAddr] <= tfWrData;
			end else if (tfWrAddr == 3'd5) begin
				head_q <= tfWrData;
			end else if (tfWrAddr == 3'd6) begin
				ctrl_q <= tfWrData;
			end
		end
	end

	// command history shift, newest at the top
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gHist
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					hist_q[g] <= {CMD_W{1'b0}};
				else if (cmdStb)
					hist_q[g] <= hist_q[g+1];
			end
		end
	endgenerate
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			hist_q[4] <= {CMD_W{1'b0}};
		else if (cmdStb)
			hist_q[4] <= cmdSnap;
	end

	// error slots: circular overwrite, a sum kept per slot for the checksum
	generate
		for (g = 0; g < 4; g = g + 1) begin : gSlot
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					slot_q[g] <= {ENTRY_W{1'b0}};
					slotSum_q[g] <= 8'h00;
					filled_q[g] <= 1'b0;
				end else if (logIt && nextIndex == g + 1) begin
					slot_q[g] <= newEntry;
					slotSum_q[g] <= newSum;
					filled_q[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// index and saturating device error count
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			index_q <= 3'd0;
			errCount_q <= 16'h0;
		end else if (logIt) begin
			index_q <= nextIndex;
			if (errCount_q != 16'hffff)
				errCount_q <= errCount_q + 16'h1;
		end
	end

	// checksum byte: two's complement of all other bytes
	reg [7:0] otherSum;
	integer s;
	always @* begin
		otherSum = `DLSB_ELOG_VERSION + {5'h00, index_q} + errCount_q[7:0] + errCount_q[15:8];
		for (s = 0; s < 4; s = s + 1) begin
			if (filled_q[s])
				otherSum = otherSum + slotSum_q[s];
		end
	end
	wire [7:0] checksum;
	assign checksum = 8'h00 - otherSum;

	// error log byte at a sector offset
	function [7:0] elogByte;
		input [8:0] a;
		reg [1:0] sl;
		reg [8:0] k;
		begin
			sl = 2'd0;
			k = 9'h000;
			elogByte = 8'h00;
			if (a == 9'h000) begin
				elogByte = `DLSB_ELOG_VERSION;
			end else if (a == 9'h002) begin
				elogByte = {5'h00, index_q};
			end else if (a >= `DLSB_SLOT0_OFS && a < `DLSB_COUNT_OFS) begin
				if (a < `DLSB_SLOT1_OFS) begin
					sl = 2'd0;
					k = a - `DLSB_SLOT0_OFS;
				end else if (a < `DLSB_SLOT2_OFS) begin
					sl = 2'd1;
					k = a - `DLSB_SLOT1_OFS;
				end else if (a < `DLSB_SLOT3_OFS) begin
					sl = 2'd2;
					k = a - `DLSB_SLOT2_OFS;
				end else begin
					sl = 2'd3;
					k = a - `DLSB_SLOT3_OFS;
				end
				if (filled_q[sl])
					elogByte = slot_q[sl][8*k +: 8];
			end else if (a == `DLSB_COUNT_OFS) begin
				elogByte = errCount_q[7:0];
			end else if (a == `DLSB_COUNT_OFS + 9'h001) begin
				elogByte = errCount_q[15:8];
			end else if (a == `DLSB_CSUM_OFS) begin
				elogByte = checksum;
			end
		end
	endfunction

	// read mux: four little-endian bytes per word
	reg [31:0] rdWord;
	reg rdErr;
	integer j;
	always @* begin
		rdWord = 32'h0;
		rdErr = 1'b0;
		for (j = 0; j < 4; j = j + 1) begin
			if (paddr[11:9] == 3'd0)
				rdWord[8*j +: 8] = dirByte({paddr[8:2], j[1:0]}, cfg_q);
			else if (paddr[11:9] == 3'd1)
				rdWord[8*j +: 8] = elogByte({paddr[8:2], j[1:0]});
		end
		if (paddr == `DLSB_CFG_ADDR)
			rdWord = {27'h0, cfg_q};
		else if (paddr == `DLSB_STAT_ADDR)
			rdWord = {errCount_q, 13'h0, index_q};
		else if (paddr[11:10] != 2'd0 || paddr[1:0] != 2'd0)
			rdErr = 1'b1;
		// only the config register is writable
		if (pwrite && paddr != `DLSB_CFG_ADDR)
			rdErr = 1'b1;
	end

	// apb slave: one wait state so every answer comes from a flip-flop
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
			cfg_q <= `DLSB_CFG_RESET;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= rdErr;
			prdata <= pwrite ? 32'h0 : rdWord;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			// write lands at the completing edge
			if (psel && penable && pready && pwrite && paddr == `DLSB_CFG_ADDR)
				cfg_q <= pwdata[4:0];
		end
	end

endmodule // dlsb_log_builder
`default_nettype wire

// ===== testbench/dlsb_log_builder_monitor.sv
// checker for the apb port of the log sector builder
`default_nettype none
module dlsb_log_builder_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// first access cycle; the answer is due one edge later
	wire logic acc = psel && penable && !pready;
	wire logic rd = acc && !pwrite;
	wire logic bad = paddr[1:0] != 2'h0 || (paddr >= 12'h400 && paddr != 12'h400 && paddr != 12'h404);
	a_ready_one: assert property (acc |=> pready) else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle outputs not zero");
	a_bad_addr: assert property (acc && bad |=> pslverr) else $error("bad address accepted");
	a_ro_write: assert property (acc && pwrite && paddr != 12'h400 |=> pslverr) else $error("read-only write taken");
	a_sector_ok: assert property (rd && paddr < 12'h400 && !bad |=> !pslverr) else $error("sector read refused");
	a_elog_ver: assert property (rd && paddr == 12'h200 |=> prdata[15:0] == 16'h0001) else $error("log version");
	a_index_max: assert property (rd && paddr == 12'h200 |=> prdata[31:16] <= 16'h4) else $error("index > 4");
	a_vend_len: assert property (rd && paddr[11:6] == 6'h4 |=> prdata == 32'h00100010 || prdata == 32'h0)
		else $error("vendor log length");
	cover property (acc && pwrite && paddr == 12'h400);
	cover property (pready && pslverr);
	cover property (rd && paddr == 12'h200);
endmodule // dlsb_log_builder_monitor
bind dlsb_log_builder dlsb_log_builder_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr));
`default_nettype wire

// ===== testbench/dlsb_host_model.sv
// apb master standing in for the host controller that reads the log sectors
`default_nettype none
module dlsb_host_model (
	// clock
	input wire logic core_clk,
	// request
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [11:0] paddr,
	output var logic [31:0] pwdata,
	// answer
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// holds the request until ready is seen at an edge, takes the answer at that edge only
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// no cycle count assumed: only the bench watchdog ends a hung wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// released lines must not keep looking valid
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge core_clk);
	endtask
endmodule // dlsb_host_model
`default_nettype wire

// ===== testbench/test_drive_log_sector_builder.sv
// self-checking bench for the log sector builder
`default_nettype none
module test_drive_log_sector_builder;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, tfWrStb, cmdStb, errStb, errFaulty;
	logic [2:0] tfWrAddr;
	logic [3:0] powerState;
	logic [4:0] cfg;
	logic [7:0] tfWrData, cmdCode, errReg, errStatus, errHead;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [63:0] errTf;
	// reference: shadow pairs, command history, both sector images
	logic [7:0] lo[8], hi[8], hs[5][18], el[512], dx[512];
	int mismatches, checked, seed, cnt, idx, cyc;
	// time stamps the reference expects, one per command and one per logged error
	int msq[$], hrq[$];
	localparam int MsCyc = 4;
	localparam int HourMs = 3;
	// short timer counts keep the run small and let the stamps be modelled exactly
	dlsb_log_builder #(.MS_CYCLES(MsCyc), .HOUR_MS(HourMs), .ELOG_SECTORS(8'h01)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .tfWrStb(tfWrStb), .tfWrAddr(tfWrAddr), .tfWrData(tfWrData),
		.cmdStb(cmdStb), .cmdCode(cmdCode), .errStb(errStb), .errFaulty(errFaulty), .errReg(errReg),
		.errStatus(errStatus), .errHead(errHead), .errTf(errTf), .powerState(powerState));
	dlsb_host_model u_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// time reference: edges seen by the time base since reset, sampled at every taken strobe
	always @(posedge core_clk) begin
		if (rst_n) begin
			if (cmdStb) msq.push_back(cyc / MsCyc);
			if (errStb && !errFaulty) hrq.push_back(cyc / (MsCyc * HourMs));
			cyc++;
		end
	end
	task automatic stop_test();
		if (mismatches == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer; refusal flag always compared, read data only when accepted
	task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic e;
		u_host.xfer(w, a, d, r, e);
		cmp({31'h0, e}, {31'h0, ee});
		if (!w && !ee) cmp(r, d);
	endtask
	// read a whole sector and compare it with the model, summing bytes on the way
	task automatic sec(input logic [11:0] b);
		logic [31:0] r, x;
		logic [7:0] s;
		logic e;
		s = 8'h0;
		if (b[9]) begin
			el[511] = 8'h0;
			for (int i = 0; i < 511; i++) el[511] -= el[i];
		end
		for (int w = 0; w < 128; w++) begin
			u_host.xfer(1'b0, b + 12'(4 * w), 32'h0, r, e);
			for (int k = 0; k < 4; k++) x[8*k+:8] = b[9] ? el[4*w+k] : dx[4*w+k];
			s += r[7:0] + r[15:8] + r[23:16] + r[31:24];
			cmp({31'h0, e}, 32'h0);
			cmp(r, x);
		end
		if (b[9]) cmp({24'h0, s}, 32'h0);
	endtask
	task automatic mkdir();
		dx = '{default: 8'h0};
		if (cfg[0]) begin
			dx[0] = 8'h01;
			dx[6] = 8'h01;
			for (int n = 128; n < 160; n++) dx[2 * n] = 8'h10;
			dx[32] = {7'h0, cfg[1]};
			dx[34] = {7'h0, cfg[2]};
			dx[36] = {7'h0, cfg[3]};
			dx[42] = {7'h0, cfg[4]};
		end
	endtask
	task automatic tfw(input logic [2:0] a, input logic [7:0] d);
		tfWrAddr <= a;
		tfWrData <= d;
		tfWrStb <= 1'b1;
		@(posedge core_clk);
		tfWrStb <= 1'b0;
		@(posedge core_clk);
		hi[a] = lo[a];
		lo[a] = d;
	endtask
	task automatic cmd(input logic [7:0] c);
		int ms;
		cmdCode <= c;
		cmdStb <= 1'b1;
		@(posedge core_clk);
		cmdStb <= 1'b0;
		@(posedge core_clk);
		ms = msq.pop_front();
		for (int i = 0; i < 4; i++) hs[i] = hs[i + 1];
		hs[4] = '{lo[6], lo[0], hi[0], lo[1], hi[1], lo[2], hi[2], lo[3], hi[3], lo[4], hi[4], lo[5], c, 8'h0,
			ms[7:0], ms[15:8], ms[23:16], ms[31:24]};
	endtask
	// error report; the strobe stays up for n edges, each one a separate error
	task automatic err(input logic f, input int n);
		int b, h;
		errFaulty <= f;
		errReg <= 8'($random(seed));
		errStatus <= 8'($random(seed));
		errHead <= 8'($random(seed));
		errTf <= {$random(seed), $random(seed)};
		powerState <= 4'({$random(seed)} % 5);
		errStb <= 1'b1;
		repeat (n) @(posedge core_clk);
		errStb <= 1'b0;
		@(posedge core_clk);
		if (!f) repeat (n) begin
			idx = idx % 4 + 1;
			if (cnt < 65535) cnt++;
			h = hrq.pop_front();
			b = 124 * idx - 120;
			for (int i = 0; i < 124; i++) el[b + i] = 8'h0;
			for (int i = 0; i < 5; i++) begin
				for (int j = 0; j < 18; j++) el[b + 18 * i + j] = hs[i][j];
			end
			b += 90;
			el[b + 1] = errReg;
			for (int k = 0; k < 8; k++) el[b + 2 + k] = errTf[8*k+:8];
			el[b + 10] = errHead;
			el[b + 11] = errStatus;
			el[b + 31] = {4'h0, powerState};
			el[b + 32] = h[7:0];
			el[b + 33] = h[15:8];
			el[2] = 8'(idx);
			el[500] = cnt[7:0];
			el[501] = cnt[15:8];
		end
	endtask
	// watchdog: the whole sequence needs about 69800 cycles, some 10000 under this many
	initial begin
		repeat (80000) @(posedge core_clk);
		mismatches++;
		stop_test();
	end
	// main sequence
	initial begin
		seed = 72412;
		rst_n = 1'b0;
		{tfWrStb, cmdStb, errStb, errFaulty, tfWrAddr, tfWrData, cmdCode, errReg, errStatus, errHead, errTf, powerState} = '0;
		lo = '{default: 8'h0};
		hi = '{default: 8'h0};
		hs = '{default: 8'h0};
		dx = '{default: 8'h0};
		el = '{default: 8'h0};
		el[0] = 8'h01;
		cfg = 5'h01;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rw(1'b0, 12'h400, 32'h1, 1'b0);
		mkdir();
		sec(12'h000);
		for (int i = 0; i < 3; i++) begin
			cfg = i == 0 ? 5'h1f : (i == 1 ? 5'($random(seed)) | 5'h01 : 5'h00);
			rw(1'b1, 12'h400, {27'h0, cfg}, 1'b0);
			rw(1'b0, 12'h400, {27'h0, cfg}, 1'b0);
			mkdir();
			sec(12'h000);
		end
		rw(1'b1, 12'h200, 32'hffffffff, 1'b1);
		rw(1'b0, 12'h408, 32'h0, 1'b1);
		rw(1'b0, 12'h202, 32'h0, 1'b1);
		sec(12'h200);
		for (int e = 0; e < 7; e++) begin
			for (int k = 0; k < 4; k++) tfw(3'($random(seed)), 8'($random(seed)));
			cmd(8'($random(seed)));
			err(e == 2, 1);
			if (e == 2) sec(12'h200);
		end
		sec(12'h200);
		err(1'b0, 65532);
		sec(12'h200);
		rw(1'b0, 12'h404, {cnt[15:0], 13'h0, 3'(idx)}, 1'b0);
		stop_test();
	end
endmodule // test_drive_log_sector_builder
`default_nettype wire
